/* File: mdsup_top.sv */
// Motor drive supervisor: switch, scaling, mode, priority, PWM gate
// and AXI4-Lite registers.
// Assumes samples come on ref_clk with a one-cycle valid;
// switch and over-current pins are asynchronous.
//
// Notes on behaviour
// RL1: Low switch runs, high stops
// RL2: CW codes 800-fff give 0-4000 rpm
// RL3: CCW codes 7ff-000 give 0-4000 rpm
// RL4: Position mode maps halves to 0-180 degrees
// RL5: Bus codes 000-fff mean 0-73.26 V
// RL6: Failed bus checks halt PWM
// RL7: Current codes mean -8.25 to +8.25 A
// RL8: Two-shunt option measures only U and W
// RL9: Sine or space-vector selectable by software
// RL10: Sine ratio is reference over bus voltage
// RL11: SVM offsets phases by minus mid-extreme
// RL12: SVM ratio is offset wave over bus
// RL13: Mode is stopped, driving or fault
// RL14: Stop, run, reset from operator; error internal
// RL15: Priority: over-current 0, scan 5, timer 10
// RL16: Periodic timer interrupt every 500 us
// RL17: Over-current pin releases all PWM outputs
// RL18: Over 60 V each period raises error
// RL19: Run, stop, error, reset move the mode
// RL20: Stopped or fault keeps PWM inactive
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "mdsup_defs.svh"
module mdsup_top (
  input wire logic ref_clk,
  input wire logic nrst,
  // Pins
  input wire logic start_switch_input,
  input wire logic over_current_n,
  // Converter samples
  input wire logic scan_valid,
  input wire logic [11:0] speed_potentiometer,
  input wire logic [11:0] adc_vbus,
  input wire logic [11:0] adc_iu,
  input wire logic [11:0] adc_iv,
  input wire logic [11:0] adc_iw,
  // PWM pins, released by enables
  output logic [5:0] pwm_out,
  output logic [5:0] pwm_oe,
  // Interrupt event and priority
  output logic periodic_timer_interrupt,
  output logic scan_complete_interrupt,
  output logic output_disable_event,
  output logic [3:0] irq_level,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int TICK_CYC = `MDSUP_TICK_CYC;

  // ==========================================================
  // Pin synchronisers, three stages each
  logic [2:0] sw_sync, oc_sync; // Stage 0 feeds stage 1 only
  logic sw_level, oc_active, sw_prev;
  logic next_sw_level, next_oc_active;

  // Accept a change once the last two stages agree
  always_comb begin
    next_sw_level = sw_level;
    next_oc_active = oc_active;
    if (sw_sync[1] == sw_sync[2]) next_sw_level = sw_sync[2];
    if (oc_sync[1] == oc_sync[2]) next_oc_active = !oc_sync[2];
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sw_sync <= 3'h7;
      oc_sync <= 3'h7;
      sw_level <= 1'b1;
      sw_prev <= 1'b1;
      oc_active <= 1'b0;
    end else begin
      sw_sync <= {sw_sync[1:0], start_switch_input};
      oc_sync <= {oc_sync[1:0], over_current_n};
      sw_level <= next_sw_level;
      sw_prev <= sw_level;
      oc_active <= next_oc_active;
    end
  end

  // Switch edges become operator events
  logic sw_run_evt, sw_stop_evt;
  assign sw_run_evt = sw_prev && !sw_level; // RL1
  assign sw_stop_evt = !sw_prev && sw_level; // RL1

  // ==========================================================
  // Converter scaling
  logic [15:0] speed_rpm, pos_deg, vbus_cv, next_vbus_cv;
  logic [15:0] next_speed_rpm, next_pos_deg;
  logic signed [15:0] iu_ma, iv_ma, iw_ma;
  logic signed [15:0] next_iu_ma, next_iv_ma, next_iw_ma;
  logic dir_ccw, next_dir_ccw; // Commanded rotation
  logic two_shunt, svm_sel, pos_mode; // Software options

  // Distance from mid-scale
  function automatic logic [10:0] half_code(input logic [11:0] c);
    half_code = c[11] ? c[10:0] : 11'(~c[10:0]);
  endfunction

  // Scale a half-range code onto 0..full
  function automatic logic [15:0] scale_half(input logic [10:0] h,
    input logic [15:0] full);
    logic [31:0] p;
    p = {21'h0, h} * {16'h0, full};
    scale_half = 16'(p / 32'h000007ff);
  endfunction

  // Signed current, mid-scale is zero
  function automatic logic signed [15:0] scale_cur(input logic [11:0] c);
    logic signed [31:0] p;
    p = (32'(signed'({1'b0, c})) - 32'sh0800) * `MDSUP_IPH_FULL_MA;
    scale_cur = 16'(p / 32'sh0800);
  endfunction

  always_comb begin
    next_dir_ccw = dir_ccw;
    next_speed_rpm = speed_rpm;
    next_pos_deg = pos_deg;
    next_vbus_cv = vbus_cv;
    next_iu_ma = iu_ma;
    next_iv_ma = iv_ma;
    next_iw_ma = iw_ma;
    if (scan_valid) begin
      next_dir_ccw = !speed_potentiometer[11];
      next_speed_rpm = scale_half(half_code(speed_potentiometer),
        16'(`MDSUP_SPEED_MAX_RPM)); // RL2 RL3
      next_pos_deg = scale_half(half_code(speed_potentiometer),
        16'(`MDSUP_POS_MAX_DEG)); // RL4
      next_vbus_cv = 16'(({20'h0, adc_vbus} * `MDSUP_VBUS_FULL_CV)
        / 32'h00000fff); // RL5
      next_iu_ma = scale_cur(adc_iu); // RL7
      next_iw_ma = scale_cur(adc_iw); // RL7
      // Two shunts: V = -(U + W)
      if (two_shunt) next_iv_ma = 16'(-(scale_cur(adc_iu)
        + scale_cur(adc_iw))); // RL8
      else next_iv_ma = scale_cur(adc_iv);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dir_ccw <= 1'b0;
      speed_rpm <= 16'h0000;
      pos_deg <= 16'h0000;
      vbus_cv <= 16'h0000;
      iu_ma <= 16'sh0000;
      iv_ma <= 16'sh0000;
      iw_ma <= 16'sh0000;
    end else begin
      dir_ccw <= next_dir_ccw;
      speed_rpm <= next_speed_rpm;
      pos_deg <= next_pos_deg;
      vbus_cv <= next_vbus_cv;
      iu_ma <= next_iu_ma;
      iv_ma <= next_iv_ma;
      iw_ma <= next_iw_ma;
    end
  end

  // ==========================================================
  // Voltage checks, once per control period
  logic vbus_ov, vbus_uv, err_evt;
  // Checked each scan, the control period
  assign vbus_ov = scan_valid && (next_vbus_cv > 16'(`MDSUP_VBUS_OV_CV)); // RL18
  assign vbus_uv = scan_valid && (next_vbus_cv < 16'(`MDSUP_VBUS_UV_CV)); // RL6
  assign err_evt = vbus_ov || vbus_uv || oc_active; // RL14

  // ==========================================================
  // Operating mode machine
  mdsup_pkg::mdsup_mode_t mode, next_mode;
  logic sw_run_cmd, sw_stop_cmd, sw_reset_cmd; // Register pulses

  always_comb begin
    next_mode = mode;
    unique case (mode)
      mdsup_pkg::MDSUP_STOPPED: begin
        if (sw_run_evt || sw_run_cmd) next_mode = mdsup_pkg::MDSUP_DRIVING; // RL19
      end
      mdsup_pkg::MDSUP_DRIVING: begin
        if (sw_stop_evt || sw_stop_cmd) next_mode = mdsup_pkg::MDSUP_STOPPED; // RL19
      end
      mdsup_pkg::MDSUP_FAULT: begin
        if (sw_reset_cmd) next_mode = mdsup_pkg::MDSUP_STOPPED; // RL19
      end
      default: next_mode = mdsup_pkg::MDSUP_FAULT;
    endcase
    // Error beats operator events
    if (err_evt) next_mode = mdsup_pkg::MDSUP_FAULT; // RL13 RL19
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) mode <= mdsup_pkg::MDSUP_STOPPED;
    else mode <= next_mode;
  end

  // ==========================================================
  // Periodic timer and interrupt priority
  logic [16:0] tick_cnt, next_tick_cnt;
  logic next_tick;

  always_comb begin
    next_tick = 1'b0;
    if (tick_cnt == 17'(TICK_CYC - 1)) begin
      next_tick_cnt = 17'h00000;
      next_tick = 1'b1; // RL16
    end else begin
      next_tick_cnt = tick_cnt + 17'h00001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 17'h00000;
      periodic_timer_interrupt <= 1'b0;
      scan_complete_interrupt <= 1'b0;
      output_disable_event <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      periodic_timer_interrupt <= next_tick;
      scan_complete_interrupt <= scan_valid;
      output_disable_event <= next_oc_active && !oc_active;
    end
  end

  // Lowest level number wins
  always_comb begin
    if (output_disable_event) irq_level = `MDSUP_PRI_OCP; // RL15
    else if (scan_complete_interrupt) irq_level = `MDSUP_PRI_SCAN; // RL15
    else if (periodic_timer_interrupt) irq_level = `MDSUP_PRI_TICK; // RL15
    else irq_level = `MDSUP_PRI_NONE;
  end

  // ==========================================================
  // Modulation and PWM gating
  logic signed [15:0] vref, wave_u, wave_v, wave_w; // vref by software
  logic [15:0] mod_ratio;
  logic [15:0] carrier; // Free-running sawtooth
  logic drive_ok;
  logic [2:0] hs; // Upper switch wanted, per phase

  mdsup_modwave u_wave (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .svm_sel(svm_sel), // RL9
    .cmd_u(vref),
    .cmd_v(16'(-(vref >>> 1))),
    .cmd_w(16'(-(vref >>> 1))),
    .vbus_cv(vbus_cv),
    .wave_u(wave_u),
    .wave_v(wave_v),
    .wave_w(wave_w),
    .mod_ratio(mod_ratio)
  );

  assign drive_ok = (mode == mdsup_pkg::MDSUP_DRIVING) && !err_evt; // RL20 RL6
  assign hs = {wave_w > signed'(carrier), wave_v > signed'(carrier),
    wave_u > signed'(carrier)};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      carrier <= 16'h0000;
      pwm_out <= 6'h00;
      pwm_oe <= 6'h00;
    end else begin
      carrier <= carrier + 16'h0100;
      if (oc_active || next_oc_active) begin
        pwm_oe <= 6'h00; // RL17
        pwm_out <= 6'h00;
      end else if (!drive_ok) begin
        pwm_oe <= 6'h3f;
        pwm_out <= 6'h00; // RL20 RL6
      end else begin
        pwm_oe <= 6'h3f;
        pwm_out <= {!hs[2], hs[2], !hs[1], hs[1], !hs[0], hs[0]};
      end
    end
  end

  // ==========================================================
  // AXI4-Lite slave, one write and one read at a time
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [2:0] opts, next_opts; // svm, two-shunt, position mode
  logic next_bvalid, next_rvalid, next_run, next_stop, next_rst;
  logic [31:0] next_rdata;
  logic [1:0] next_bresp, next_rresp;
  logic signed [15:0] next_vref;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign svm_sel = opts[0];
  assign two_shunt = opts[1];
  assign pos_mode = opts[2];

  always_comb begin
    next_aw_held = aw_held || (s_axi_awvalid && s_axi_awready);
    next_w_held = w_held || (s_axi_wvalid && s_axi_wready);
    next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_opts = opts;
    next_vref = vref;
    next_run = 1'b0;
    next_stop = 1'b0;
    next_rst = 1'b0;
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = 2'b00;
      if (aw_addr == `MDSUP_REG_CTRL) begin
        next_run = w_data[`MDSUP_CTRL_RUN]; // RL14
        next_stop = w_data[`MDSUP_CTRL_STOP]; // RL14
        next_rst = w_data[`MDSUP_CTRL_RESET]; // RL14
        next_opts = {w_data[`MDSUP_CTRL_POSMODE], w_data[`MDSUP_CTRL_TWOSH],
          w_data[`MDSUP_CTRL_SVM]};
      end else if (aw_addr == `MDSUP_REG_VREF) begin
        next_vref = w_data[15:0];
      end else begin
        next_bresp = 2'b10; // Unmapped or read-only
      end
    end
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = 2'b00;
      unique case (s_axi_araddr)
        `MDSUP_REG_CTRL: next_rdata = {26'h0, opts, 3'h0};
        `MDSUP_REG_STATUS: next_rdata = {26'h0, sw_level, oc_active,
          dir_ccw, pos_mode, mode};
        `MDSUP_REG_SPEED: next_rdata = {16'h0, speed_rpm};
        `MDSUP_REG_POS: next_rdata = {16'h0, pos_deg};
        `MDSUP_REG_VBUS: next_rdata = {16'h0, vbus_cv};
        `MDSUP_REG_IU: next_rdata = {16'h0, iu_ma};
        `MDSUP_REG_IV: next_rdata = {16'h0, iv_ma};
        `MDSUP_REG_IW: next_rdata = {16'h0, iw_ma};
        `MDSUP_REG_VREF: next_rdata = {16'h0, vref};
        `MDSUP_REG_MOD: next_rdata = {16'h0, mod_ratio};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = 2'b10;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
      opts <= 3'h0;
      vref <= 16'sh0000;
      sw_run_cmd <= 1'b0;
      sw_stop_cmd <= 1'b0;
      sw_reset_cmd <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      opts <= next_opts;
      vref <= next_vref;
      sw_run_cmd <= next_run;
      sw_stop_cmd <= next_stop;
      sw_reset_cmd <= next_rst;
    end
  end
endmodule
`default_nettype wire

/* File: mdsup_defs.svh */
// Supervisor constants: scaling, limits, timing, offsets.
// Assumes inclusion by bare name.
`ifndef MDSUP_DEFS_SVH
`define MDSUP_DEFS_SVH
// ==========================================================
// Converter scaling
`define MDSUP_SPEED_MAX_RPM 4000
`define MDSUP_POS_MAX_DEG 180
// Bus full scale in centivolts
`define MDSUP_VBUS_FULL_CV 7326
// Phase current full scale in mA
`define MDSUP_IPH_FULL_MA 8250
// Limits in centivolts
`define MDSUP_VBUS_OV_CV 6000
`define MDSUP_VBUS_UV_CV 800
// ==========================================================
// Timing
`define MDSUP_CLK_HZ 200000000
`define MDSUP_TICK_US 500
`define MDSUP_TICK_CYC (`MDSUP_CLK_HZ / 1000000 * `MDSUP_TICK_US)
// ==========================================================
// Interrupt priority levels
`define MDSUP_PRI_OCP 4'h0
`define MDSUP_PRI_SCAN 4'h5
`define MDSUP_PRI_TICK 4'ha
`define MDSUP_PRI_NONE 4'hf
// ==========================================================
// Register byte offsets
`define MDSUP_REG_CTRL 12'h000
`define MDSUP_REG_STATUS 12'h004
`define MDSUP_REG_SPEED 12'h008
`define MDSUP_REG_POS 12'h00c
`define MDSUP_REG_VBUS 12'h010
`define MDSUP_REG_IU 12'h014
`define MDSUP_REG_IV 12'h018
`define MDSUP_REG_IW 12'h01c
`define MDSUP_REG_VREF 12'h020
`define MDSUP_REG_MOD 12'h024
// Control fields
`define MDSUP_CTRL_RUN 0
`define MDSUP_CTRL_STOP 1
`define MDSUP_CTRL_RESET 2
`define MDSUP_CTRL_SVM 3
`define MDSUP_CTRL_TWOSH 4
`define MDSUP_CTRL_POSMODE 5
`endif

/* File: mdsup_pkg.sv */
// Types shared by the supervisor modules.
// Used by scoped name.
package mdsup_pkg;
  // ==========================================================
  // Operating modes
  typedef enum logic [1:0] {
    MDSUP_STOPPED,
    MDSUP_DRIVING,
    MDSUP_FAULT
  } mdsup_mode_t;
endpackage

/* File: mdsup_modwave.sv */
// Modulation wave: sine or space-vector offset, and ratio.
// Assumes steady inputs over a cycle.
`timescale 1ns/10ps
`default_nettype none
module mdsup_modwave (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic svm_sel,
  input wire logic signed [15:0] cmd_u,
  input wire logic signed [15:0] cmd_v,
  input wire logic signed [15:0] cmd_w,
  input wire logic [15:0] vbus_cv,
  output logic signed [15:0] wave_u,
  output logic signed [15:0] wave_v,
  output logic signed [15:0] wave_w,
  output logic [15:0] mod_ratio
);
  // ==========================================================
  // Offset and ratio computation
  logic signed [15:0] vmax, vmin; // Command extremes
  logic signed [16:0] offs; // Minus half the extremes' sum
  logic signed [15:0] next_wave_u, next_wave_v, next_wave_w;
  logic [15:0] next_mod_ratio;
  logic [15:0] peak; // Magnitude of u-phase wave
  logic [31:0] num;

  function automatic logic signed [15:0] max2(
    input logic signed [15:0] a, input logic signed [15:0] b);
    max2 = (a > b) ? a : b;
  endfunction

  function automatic logic signed [15:0] min2(
    input logic signed [15:0] a, input logic signed [15:0] b);
    min2 = (a < b) ? a : b;
  endfunction

  // Combinational wave shaping
  always_comb begin
    vmax = max2(max2(cmd_u, cmd_v), cmd_w);
    vmin = min2(min2(cmd_u, cmd_v), cmd_w);
    // Shift before adding would lose the lsb; sum at 17 bits first
    offs = -((17'(vmax) + 17'(vmin)) >>> 1);
    if (svm_sel) begin
      // Common-mode offset lifts usable line voltage
      next_wave_u = 16'(17'(cmd_u) + offs); // RL11
      next_wave_v = 16'(17'(cmd_v) + offs); // RL11
      next_wave_w = 16'(17'(cmd_w) + offs); // RL11
    end else begin
      next_wave_u = cmd_u;
      next_wave_v = cmd_v;
      next_wave_w = cmd_w;
    end
    // Q12 ratio of wave over bus
    peak = next_wave_u[15] ? 16'(-next_wave_u) : next_wave_u;
    num = {4'h0, peak, 12'h000};
    if (vbus_cv == 16'h0000) begin
      // No bus: report zero rather than divide by zero
      next_mod_ratio = 16'h0000;
    end else begin
      next_mod_ratio = 16'(num / {16'h0000, vbus_cv}); // RL10 RL12
    end
  end

  // Register outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wave_u <= 16'sh0000;
      wave_v <= 16'sh0000;
      wave_w <= 16'sh0000;
      mod_ratio <= 16'h0000;
    end else begin
      wave_u <= next_wave_u;
      wave_v <= next_wave_v;
      wave_w <= next_wave_w;
      mod_ratio <= next_mod_ratio;
    end
  end
endmodule
`default_nettype wire

/* File: mdsup_top_assertions.sv */
// Checker for the supervisor top.
// Assumes binding to mdsup_top; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module mdsup_chk (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic over_current_n,
  input wire logic scan_valid,
  input wire logic [11:0] adc_vbus,
  input wire logic [5:0] pwm_oe,
  input wire logic [5:0] pwm_out,
  input wire logic periodic_timer_interrupt,
  input wire logic scan_complete_interrupt,
  input wire logic output_disable_event,
  input wire logic [3:0] irq_level,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  // ==========
  // Single clock domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Sync is three flops, so six low samples leave margin
  chk_oc_tristate:
    assert property (!over_current_n [*6] |-> pwm_oe == 6'h00)
    else $error("PWM driven during over-current");
  chk_oc_event:
    assert property ($fell(over_current_n) |-> ##[2:6] output_disable_event)
    else $error("No output disable event");
  chk_irq_top:
    assert property (output_disable_event |-> irq_level == 4'h0)
    else $error("Over-current not at level 0");
  chk_irq_scan:
    assert property (scan_complete_interrupt && !output_disable_event
      |-> irq_level == 4'h5)
    else $error("Scan event not at level 5");
  chk_irq_tick:
    assert property (periodic_timer_interrupt && !scan_complete_interrupt
      && !output_disable_event |-> irq_level == 4'ha)
    else $error("Timer event not at level 10");
  chk_irq_none:
    assert property (!(periodic_timer_interrupt || scan_complete_interrupt
      || output_disable_event) |-> irq_level == 4'hf)
    else $error("Level shown with no event");
  chk_scan_echo:
    assert property (1'b1 |=> scan_complete_interrupt == $past(scan_valid))
    else $error("Scan event late");
  // Codes 1c0 and d1b are the first inside 8 V and above 60 V
  chk_volt_halt:
    assert property (scan_valid && (adc_vbus >= 12'hd1b
      || adc_vbus < 12'h1c0) |-> ##[1:3] pwm_out == 6'h00)
    else $error("PWM not halted on bus fault");
  cover property (scan_complete_interrupt);
  cover property (output_disable_event);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind mdsup_top mdsup_chk u_chk (.ref_clk, .nrst, .over_current_n,
  .scan_valid, .adc_vbus, .pwm_oe, .pwm_out, .periodic_timer_interrupt,
  .scan_complete_interrupt, .output_disable_event, .irq_level,
  .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

/* File: mdsup_plant.sv */
// Far side: inverter, motor, sensors and converter.
// Assumes bench-set codes; a scan ends every 32 cycles.
`timescale 1ns/10ps
`default_nettype none
module mdsup_plant (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [11:0] cmd_pot,
  input wire logic [11:0] cmd_vbus,
  input wire logic [11:0] cmd_iu,
  input wire logic [11:0] cmd_iv,
  input wire logic [11:0] cmd_iw,
  input wire logic cmd_oc,
  output logic scan_valid,
  output logic [11:0] speed_potentiometer,
  output logic [11:0] adc_vbus,
  output logic [11:0] adc_iu,
  output logic [11:0] adc_iv,
  output logic [11:0] adc_iw,
  output logic over_current_n
);
  logic [4:0] scan_cnt; // Scan pacing
  logic [59:0] smp; // All five codes
  assign {speed_potentiometer, adc_vbus, adc_iu, adc_iv, adc_iw} = smp;
  // ==========
  // Codes toggle off the scan pulse, so late sampling shows garbage
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scan_cnt <= 5'h00;
      scan_valid <= 1'b0;
      smp <= '0;
      over_current_n <= 1'b1;
    end else begin
      scan_cnt <= scan_cnt + 5'h01;
      scan_valid <= (scan_cnt == 5'h1f);
      if (scan_cnt == 5'h1f) begin
        smp <= {cmd_pot, cmd_vbus, cmd_iu, cmd_iv, cmd_iw};
      end else begin
        smp <= ~smp;
      end
      over_current_n <= !cmd_oc;
    end
  end
endmodule
`default_nettype wire

/* File: mdsup_tb.sv */
// Self-checking bench for mdsup_top with the plant model behind it.
// Assumes the register map and latencies of mdsup_top.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk, nrst, start_switch_input, cmd_oc, scan_valid;
  logic over_current_n, periodic_timer_interrupt;
  logic scan_complete_interrupt, output_disable_event;
  logic [11:0] speed_potentiometer, adc_vbus, adc_iu, adc_iv, adc_iw;
  logic [11:0] cmd_pot, cmd_vbus, cmd_iu, cmd_iv, cmd_iw;
  logic [5:0] pwm_out, pwm_oe;
  logic [3:0] irq_level, s_axi_wstrb;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  integer fails = 0, n_tests = 0, cycles = 0, seed;
  mdsup_top DUT (.ref_clk, .nrst, .start_switch_input, .over_current_n,
    .scan_valid, .speed_potentiometer, .adc_vbus, .adc_iu, .adc_iv,
    .adc_iw, .pwm_out, .pwm_oe, .periodic_timer_interrupt,
    .scan_complete_interrupt, .output_disable_event, .irq_level,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  mdsup_plant u_plant (.ref_clk, .nrst, .cmd_pot, .cmd_vbus, .cmd_iu,
    .cmd_iv, .cmd_iw, .cmd_oc, .scan_valid, .speed_potentiometer,
    .adc_vbus, .adc_iu, .adc_iv, .adc_iw, .over_current_n);
  // ==========
  // 200 MHz clock and the hang guard
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  // ==========
  // Model current in mA, truncated toward zero
  function automatic int cur(input logic [11:0] c);
    return (int'(c) - 2048) * 8250 / 2048;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Write: both channels offered, each dropped once taken
  task axw(input logic [11:0] a, input logic [31:0] d,
           output logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axr(input logic [11:0] a, output logic [31:0] d,
           output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, e);
  endtask
  // Wait two scans for fresh samples
  task scan2;
    repeat (2) begin
      do @(posedge ref_clk); while (scan_valid !== 1'b1);
    end
    repeat (2) @(posedge ref_clk);
  endtask
  // Mode moves two cycles after a write; wait four
  task st(input logic [1:0] m);
    logic [31:0] d;
    logic [1:0] r;
    repeat (4) @(posedge ref_clk);
    axr(12'h004, d, r);
    chk({30'h0, d[1:0]}, {30'h0, m});
  endtask
  // ==========
  // Main sequence
  initial begin : main
    logic [31:0] d;
    logic [1:0] r;
    int i, h, u, w;
    seed = 50203;
    {nrst, cmd_oc, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    start_switch_input = 1'b1;
    {cmd_pot, cmd_iu, cmd_iv, cmd_iw} = {4{12'h800}};
    cmd_vbus = 12'h600;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    rc(12'h000, 32'h0);
    chk({26'h0, pwm_out}, 32'h0);
    axr(12'h0fc, d, r);
    chk({30'h0, r}, 32'h2);
    axw(12'h004, 32'h1, r);
    chk({30'h0, r}, 32'h2);
    // Random codes; odd passes use the two-shunt option
    for (i = 0; i < 6; i++) begin
      {cmd_pot, cmd_iu} <= 24'($random(seed));
      {cmd_iv, cmd_iw} <= 24'($random(seed));
      cmd_vbus <= 12'h1c0 + 12'({$random(seed)} % 2900);
      axw(12'h000, i[0] ? 32'h30 : 32'h20, r);
      scan2;
      rc(12'h000, i[0] ? 32'h30 : 32'h20);
      h = (cmd_pot >= 12'h800) ? cmd_pot - 2048 : 2047 - cmd_pot;
      u = cur(cmd_iu);
      w = cur(cmd_iw);
      rc(12'h008, h * 4000 / 2047);
      rc(12'h00c, h * 180 / 2047);
      rc(12'h010, cmd_vbus * 7326 / 4095);
      rc(12'h014, {16'h0, 16'(u)});
      rc(12'h018, {16'h0, 16'(i[0] ? -(u + w) : cur(cmd_iv))});
      rc(12'h01c, {16'h0, 16'(w)});
      rc(12'h004, (cmd_pot < 12'h800) ? 32'h2c : 32'h24);
    end
    // Run, stop, then over-current while driving
    axw(12'h000, 32'h21, r);
    st(2'd1);
    axw(12'h000, 32'h22, r);
    st(2'd0);
    axw(12'h000, 32'h21, r);
    cmd_oc <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk({26'h0, pwm_oe}, 32'h0);
    st(2'd2);
    cmd_oc <= 1'b0;
    repeat (10) @(posedge ref_clk);
    axw(12'h000, 32'h24, r);
    st(2'd0);
    // Over- then under-voltage
    for (i = 0; i < 2; i++) begin
      cmd_vbus <= i[0] ? 12'h010 : 12'hfff;
      scan2;
      st(2'd2);
      chk({26'h0, pwm_out}, 32'h0);
      cmd_vbus <= 12'h600;
      scan2;
      axw(12'h000, 32'h24, r);
      st(2'd0);
    end
    // Start switch: low runs, high stops
    start_switch_input <= 1'b0;
    repeat (8) @(posedge ref_clk);
    st(2'd1);
    start_switch_input <= 1'b1;
    repeat (8) @(posedge ref_clk);
    st(2'd0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
